// *** src/pprl_defines.svh ***
`ifndef PPRL_DEFINES_SVH
`define PPRL_DEFINES_SVH

// Reset indicator stretch with the PLL bypassed, in clock cycles
`define PPRL_RST_HOLD_CYC 512
// PLL lock base time in microseconds
`define PPRL_PLL_LOCK_US 100
// Clock rate in MHz
`define PPRL_CLK_MHZ 20
// Reset values of the port data (loaded inverted onto the pins) and direction (1 = output)
`define PPRL_DIR_RST 8'h10
`define PPRL_DOUT_RST 8'h10

`endif

// *** src/pprl_pkg.sv ***
package pprl_pkg;

    // Joint decode of the three test straps
    typedef enum logic [1:0] {
        PPRL_MODE_FUNC,
        PPRL_MODE_PLL_TEST,
        PPRL_MODE_SELFTEST,
        PPRL_MODE_SCAN
    } pprl_mode_t;

    typedef enum logic [1:0] {
        PPRL_RST_HELD,
        PPRL_RST_STRETCH,
        PPRL_RST_DONE
    } pprl_rst_st_t;

endpackage : pprl_pkg

// *** src/pprl_port.sv ***
// What this block does
// - The reset indicator pin is asserted while the external reset input is active.
// - With the PLL bypassed the indicator stays asserted 512 cycles after reset release.
// - With the PLL on the indicator stays asserted 100 us times the VCO to crystal ratio.
// - After reset the indicator pin is left as a driven output, not an input.
// - The four low group C pins each carry one level interrupt request.
// - Level interrupt inputs are asynchronous and pass two flip-flops before use.
// - A level request stays active until its input level changes or its enable is cleared; no self clear.
// - Bit-rate and timer logic is not in this block; crystal domain clocking lives outside it.
// - The three test straps are decoded jointly into a test mode.
`timescale 1ns/10ps
`default_nettype none
`include "pprl_defines.svh"

module pprl_port
    import pprl_pkg::*;
#(
    parameter int RST_HOLD_CYC = `PPRL_RST_HOLD_CYC,
    parameter int LOCK_US = `PPRL_PLL_LOCK_US,
    parameter int CLK_MHZ = `PPRL_CLK_MHZ,
    parameter int VCO_RATIO = 1
)
(
    // Clock and reset
    input wire logic ref_clk,
    input wire logic sys_rst,
    // PLL state
    input wire logic pll_enable,
    // Test straps, active low, asynchronous
    input wire logic pll_test_strap_n,
    input wire logic selftest_strap_n,
    input wire logic scan_strap_n,
    output logic [1:0] test_mode,
    // Core side port data
    input wire logic [7:0] port_group_c_dout,
    input wire logic [7:0] port_group_c_dir,
    input wire logic [7:0] port_group_c_alt_sel,
    input wire logic [7:0] port_group_c_alt_out,
    input wire logic [7:0] port_group_c_alt_oe,
    output logic [7:0] port_group_c_din,
    // Pins; oe_n low means driven
    input wire logic [7:0] port_group_c_i,
    output logic [7:0] port_group_c_o,
    output logic [7:0] port_group_c_oe_n,
    // Level interrupts and reset indicator level
    input wire logic [3:0] level_irq_en,
    output logic [3:0] level_irq_req,
    output logic reset_state_indicator
);

    // Lock stretch count; crystal domain clocking lives outside this block
    localparam int LOCK_CYC = LOCK_US * CLK_MHZ * VCO_RATIO;
    localparam int CNT_W = $clog2((LOCK_CYC > RST_HOLD_CYC ? LOCK_CYC : RST_HOLD_CYC) + 1);

    typedef struct packed {
        logic [7:0] sync1;
        logic [7:0] sync2;
        logic [2:0] strap_s1;
        logic [2:0] strap_s2;
        pprl_rst_st_t rst_st;
        logic [CNT_W-1:0] cnt;
        logic strap_cap;
        pprl_mode_t mode;
        logic [3:0] irq;
        logic [7:0] din;
        logic [7:0] pin_o;
        logic [7:0] pin_oe_n;
        logic ind;
    } pprl_state_t;

    pprl_state_t st_r;
    pprl_state_t st_nxt;

    ////////////////////////////////////////////////////////////////////////////
    always_comb
    begin
        st_nxt = st_r;
        st_nxt.sync1 = port_group_c_i;
        st_nxt.sync2 = st_r.sync1;
        st_nxt.strap_s1 = {pll_test_strap_n, selftest_strap_n, scan_strap_n};
        st_nxt.strap_s2 = st_r.strap_s1;
        st_nxt.din = st_r.sync2;

        // Reset indicator stretch
        case (st_r.rst_st)
            PPRL_RST_HELD:
            begin
                st_nxt.rst_st = PPRL_RST_STRETCH;
                if (pll_enable)
                    st_nxt.cnt = CNT_W'(LOCK_CYC - 1);
                else
                    st_nxt.cnt = CNT_W'(RST_HOLD_CYC - 1);
            end
            PPRL_RST_STRETCH:
            begin
                if (st_r.cnt == '0)
                    st_nxt.rst_st = PPRL_RST_DONE;
                else
                    st_nxt.cnt = st_r.cnt - CNT_W'(1);
            end
            PPRL_RST_DONE:
                st_nxt.rst_st = PPRL_RST_DONE;
            default:
                st_nxt.rst_st = PPRL_RST_HELD;
        endcase
        st_nxt.ind = (st_nxt.rst_st != PPRL_RST_DONE);

        // Straps are caught once, after reset release, when synchronised
        if (!st_r.strap_cap && st_r.rst_st == PPRL_RST_STRETCH)
        begin
            st_nxt.strap_cap = 1'b1;
            case (st_r.strap_s2)
                3'h3: st_nxt.mode = PPRL_MODE_PLL_TEST;
                3'h5: st_nxt.mode = PPRL_MODE_SELFTEST;
                3'h6: st_nxt.mode = PPRL_MODE_SCAN;
                default: st_nxt.mode = PPRL_MODE_FUNC;
            endcase
        end

        // Request follows the synchronised level gated by level_irq_en; nothing clears it else
        st_nxt.irq = st_r.sync2[3:0] & level_irq_en;

        // Pin mux: alternate function wins over general data
        for (int i = 0; i < 8; i++)
        begin
            if (port_group_c_alt_sel[i])
            begin
                st_nxt.pin_o[i] = port_group_c_alt_out[i];
                st_nxt.pin_oe_n[i] = ~port_group_c_alt_oe[i];
            end
            else
            begin
                st_nxt.pin_o[i] = port_group_c_dout[i];
                st_nxt.pin_oe_n[i] = ~port_group_c_dir[i];
            end
        end
        // Indicator pin is forced out until the stretch ends
        if (st_nxt.ind)
        begin
            st_nxt.pin_o[4] = 1'b0;
            st_nxt.pin_oe_n[4] = 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    always_ff @(posedge ref_clk)
    begin
        if (sys_rst)
        begin
            st_r <= '0;
            st_r.rst_st <= PPRL_RST_HELD;
            st_r.ind <= 1'b1;
            st_r.pin_o <= ~(`PPRL_DOUT_RST);
            st_r.pin_oe_n <= ~(`PPRL_DIR_RST);
            // Straps keep sampling through reset so the pair is full at release
            st_r.strap_s1 <= {pll_test_strap_n, selftest_strap_n, scan_strap_n};
            st_r.strap_s2 <= st_r.strap_s1;
        end
        else
        begin
            st_r <= st_nxt;
        end
    end

    assign test_mode = st_r.mode;
    assign port_group_c_din = st_r.din;
    assign port_group_c_o = st_r.pin_o;
    assign port_group_c_oe_n = st_r.pin_oe_n;
    assign level_irq_req = st_r.irq;
    assign reset_state_indicator = st_r.ind;

endmodule : pprl_port
`default_nettype wire

// *** tb/pprl_chk_checker.sv ***
`timescale 1ns/10ps
`default_nettype none
module pprl_chk #(parameter int H = 8, parameter int L = 20)
(
    // Clock, reset, PLL
    input wire logic ref_clk,
    input wire logic sys_rst,
    input wire logic pll_enable,
    // Port group C
    input wire logic [7:0] port_group_c_dout,
    input wire logic [7:0] port_group_c_alt_sel,
    input wire logic [7:0] port_group_c_alt_out,
    input wire logic [7:0] port_group_c_i,
    input wire logic [7:0] port_group_c_o,
    input wire logic [7:0] port_group_c_oe_n,
    // Requests and indicator
    input wire logic [3:0] level_irq_en,
    input wire logic [3:0] level_irq_req,
    input wire logic reset_state_indicator
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (sys_rst);
    // Stretch length; PLL choice must hold steady across one release
    int n_r;
    int e;
    logic [7:0] want;
    assign e = pll_enable ? L : H;
    assign want = port_group_c_alt_sel & port_group_c_alt_out | ~port_group_c_alt_sel & port_group_c_dout;
    always_ff @(posedge ref_clk)
        n_r <= (sys_rst || !reset_state_indicator) ? 0 : n_r + 1;
    ////////////////////////////////////////////////////////////
    sequence s_rel; $fell(sys_rst); endsequence
    property p_rst; disable iff (1'h0) sys_rst |=> reset_state_indicator; endproperty
    property p_hold; s_rel |-> reset_state_indicator [*8]; endproperty
    property p_len; $fell(reset_state_indicator) |-> n_r - e inside {[0:3]}; endproperty
    property p_pin4; reset_state_indicator |-> !port_group_c_oe_n[4] && !port_group_c_o[4]; endproperty
    property p_irq; level_irq_req == ($past(port_group_c_i[3:0], 3) & $past(level_irq_en)); endproperty
    property p_alt;
        !$past(sys_rst) |->
            ((port_group_c_o ^ $past(want)) & {3'h7, !reset_state_indicator, 4'hf}) == 8'h0;
    endproperty
    a_rst: assert property (p_rst) else $error("indicator low in reset");
    a_hold: assert property (p_hold) else $error("stretch cut short");
    a_len: assert property (p_len) else $error("stretch length wrong");
    a_pin4: assert property (p_pin4) else $error("pin 4 not driven low");
    a_irq: assert property (p_irq) else $error("request level wrong");
    a_alt: assert property (p_alt) else $error("pin source wrong");
endmodule : pprl_chk
bind pprl_port pprl_chk #(.H(RST_HOLD_CYC), .L(LOCK_US * CLK_MHZ * VCO_RATIO)) u_chk (.*);
`default_nettype wire

// *** tb/pprl_board.sv ***
`timescale 1ns/10ps
`default_nettype none
module pprl_board
(
    // Device pins
    input wire logic [7:0] port_group_c_o,
    input wire logic [7:0] port_group_c_oe_n,
    output logic [7:0] port_group_c_i,
    // Board sources, each holding its level until changed
    input wire logic [7:0] src
);
    assign port_group_c_i = ~port_group_c_oe_n & port_group_c_o | port_group_c_oe_n & src;
endmodule : pprl_board
`default_nettype wire

// *** tb/tb.sv ***
`timescale 1ns/10ps
`default_nettype none
module tb;
    logic ref_clk = 1'h0, sys_rst = 1'h1, pll_enable = 1'h0;
    logic pll_test_strap_n = 1'h1, selftest_strap_n = 1'h1, scan_strap_n = 1'h1;
    logic [7:0] port_group_c_dout = 8'h10, port_group_c_dir = 8'h10, src = 8'h0;
    logic [7:0] port_group_c_alt_sel = 8'h0, port_group_c_alt_out = 8'h0;
    logic [7:0] port_group_c_alt_oe = 8'h0, port_group_c_din, port_group_c_i;
    logic [7:0] port_group_c_o, port_group_c_oe_n;
    logic [3:0] level_irq_en = 4'hf, level_irq_req;
    logic [1:0] test_mode;
    logic reset_state_indicator;
    int miscompares = 0, num_checks = 0;
    pprl_port #(.RST_HOLD_CYC(8), .LOCK_US(1)) uut (.*);
    pprl_board u_board (.*);
    initial forever #25 ref_clk = ~ref_clk;
    ////////////////////////////////////////////////////////////
    task automatic chk(logic [7:0] got, logic [7:0] exp);
        num_checks++;
        if (got !== exp)
        begin
            miscompares++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    task automatic cyc(int k);
        repeat (k) @(negedge ref_clk);
    endtask : cyc
    task automatic print_verdict;
        if (miscompares == 0 && num_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : print_verdict
    task automatic t_reset(logic pe, int exp);
        int n;
        pll_enable = pe;
        sys_rst = 1'h1;
        cyc(10);
        chk({reset_state_indicator, port_group_c_oe_n[4], port_group_c_o[4]}, 8'h4);
        sys_rst = 1'h0;
        n = 0;
        while (reset_state_indicator === 1'h1 && n < 99)
        begin
            cyc(1);
            n++;
        end
        chk(n - exp inside {[0:3]}, 8'h1);
        if (n == 99)
            print_verdict;
    endtask : t_reset
    task automatic t_irq;
        level_irq_en = 4'h7;
        src = 8'h0f;
        cyc(4);
        chk(level_irq_req, 8'h7);
        chk(port_group_c_din[3:0], 8'hf);
        cyc(20);
        chk(level_irq_req, 8'h7);
        src = 8'h01;
        cyc(4);
        chk(level_irq_req, 8'h1);
        src = 8'h0;
    endtask : t_irq
    task automatic t_alt;
        {port_group_c_dout, port_group_c_dir, port_group_c_alt_sel, port_group_c_alt_out,
            port_group_c_alt_oe} = 40'ha5_f0_0f_0a_03;
        cyc(2);
        chk(port_group_c_o & 8'hef, 8'haa);
        chk(port_group_c_oe_n, 8'h0c);
    endtask : t_alt
    task automatic t_mode;
        logic [2:0] pat [5] = '{3'h7, 3'h3, 3'h5, 3'h6, 3'h0};
        logic [1:0] mv [5] = '{2'h0, 2'h1, 2'h2, 2'h3, 2'h0};
        for (int i = 0; i < 5; i++)
        begin
            {pll_test_strap_n, selftest_strap_n, scan_strap_n} = pat[i];
            t_reset(1'h0, 8);
            chk(test_mode, mv[i]);
        end
        {pll_test_strap_n, selftest_strap_n, scan_strap_n} = 3'h7;
    endtask : t_mode
    initial
    begin
        t_reset(1'h0, 8);
        t_irq;
        t_alt;
        t_mode;
        t_reset(1'h1, 20);
        print_verdict;
    end
endmodule : tb
`default_nettype wire
